// ===== hdl/rscs_defs.svh
// timing counts, stop-style codes and reference width for the run/stop contactor sequencer
`ifndef RSCS_DEFS_SVH
`define RSCS_DEFS_SVH
`define RSCS_CLK_HZ 100000000
`define RSCS_DISABLE_DELAY_MS 30
`define RSCS_DISABLE_DELAY_CYC ((`RSCS_CLK_HZ / 1000) * `RSCS_DISABLE_DELAY_MS)
`define RSCS_DEBOUNCE_CYC 1000
`define RSCS_STOP_RAMP 1'b0
`define RSCS_STOP_COAST 1'b1
`define RSCS_REF_W 16
`endif

// ===== hdl/rscs_pkg.sv
// types of the run/stop contactor sequencer
package rscs_pkg;
  typedef struct packed {
    logic run_pb;
    logic jog_pb;
    logic stop_pb;
    logic interlock_ok;
    logic contactor_aux;
    logic reverse_sw;
  } rscs_pins_t;
  typedef struct packed {
    logic power_stage_en;
    logic ref_unclamped;
    logic jog_select;
    logic reverse;
    logic phaseback;
  } rscs_ctrl_t;
endpackage

// ===== hdl/rscs_sync.sv
// three-stage synchroniser with debounce, one per bit
`timescale 1ns/1ps
`include "rscs_defs.svh"
module rscs_sync #(
  parameter int W = 6,
  parameter int DEB = `RSCS_DEBOUNCE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] din_i,
  output logic [W-1:0] dout_o
);
  // ****************************************
  // per-bit synchroniser and filter
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_ff, s2_ff, s3_ff, q_ff;
      logic [$clog2(DEB+1)-1:0] cnt_ff;
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
        end else begin
          s1_ff <= din_i[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end
      // only stages two and three are compared; stage one feeds stage two only
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          cnt_ff <= '0;
          q_ff <= 1'b0;
        end else if (s2_ff != s3_ff || s3_ff == q_ff) begin
          cnt_ff <= '0;
        end else if (cnt_ff == ($clog2(DEB+1))'(DEB - 1)) begin
          cnt_ff <= '0;
          q_ff <= s3_ff;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
      assign dout_o[g] = q_ff;
    end
  endgenerate
endmodule

// ===== hdl/rscs_top.sv
// run, stop and jog sequencing with contactor hold-in and phaseback interlock
// ****************************************
// How it works
// - power stage on while enable low; off 30 ms after release.
// - run permit and reference on low unclamp reference; enable low accelerates.
// - releasing them clamps reference; enable kept low ramps down (ramp stop).
// - enable released too gives coast or dynamic braking (coast stop).
// - jog select low picks jog reference instead of speed reference.
// - reverse low inverts the active reference polarity.
// - phaseback status high while phased forward, low once fully phased back.
// - contactor held through phaseback relay until phaseback completes.
// - no-fault relay on while powered and fault free.
// - open interlock drops trip relay; external trip only while open.
// - relay two defaults to drive reset; relay one to reverse.
// - run energises contactor; its aux turns on both aux relays, pulling inputs low.
// - three-wire run latches through run contact and aux relay a.
// - two-wire has no latch; stops when run input opens.
// - phaseback relay bypasses run contact only once aux relay b is on.
// - energised contactor drops coil to reduced holding voltage.
// - spare aux b contact closed in run or jog, open when contactor opens.
// - ramp stop drops contactor after phaseback; locked out until new run.
// - coast stop phases back at once and opens contactor.
// - jog follows run, but never latches in either wiring; drops when jog contact opens.
// - during jog, jog select is also asserted.
// ****************************************
`timescale 1ns/1ps
`include "rscs_defs.svh"
module rscs_top
  import rscs_pkg::*;
#(
  parameter int DISABLE_DELAY_CYC = `RSCS_DISABLE_DELAY_CYC,
  parameter int DEBOUNCE_CYC = `RSCS_DEBOUNCE_CYC,
  parameter int REF_W = `RSCS_REF_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire rscs_pkg::rscs_pins_t pins_i,
  input wire logic stop_style_jumper_i,
  input wire logic three_wire_i,
  input wire logic relay_two_function_jumper_i,
  input wire logic nofault_contact_polarity_jumper_i,
  input wire logic power_ok_i,
  input wire logic drive_fault_i,
  input wire logic at_zero_speed_i,
  input wire logic relay_two_cmd_i,
  input wire logic signed [REF_W-1:0] speed_ref_i,
  input wire logic signed [REF_W-1:0] jog_ref_i,
  output rscs_pkg::rscs_ctrl_t ctrl_o,
  output logic signed [REF_W-1:0] ref_o,
  output logic contactor_coil_o,
  output logic coil_reduced_o,
  output logic contactor_aux_relay_a_o,
  output logic contactor_aux_relay_b_o,
  output logic zero_speed_phaseback_relay_o,
  output logic phaseback_status_output_o,
  output logic spare_aux_contact_o,
  output logic no_fault_relay_o,
  output logic trip_relay_o,
  output logic external_trip_o,
  output logic programmable_relay_one_o,
  output logic programmable_relay_two_o,
  output logic drive_reset_o,
  output logic relay_two_programmable_input_o
);
  import rscs_pkg::*;

  // ****************************************
  // input conditioning
  // ****************************************
  rscs_pins_t pins_s;
  logic [5:0] pins_raw;
  logic [5:0] pins_clean;
  assign pins_raw = pins_i;
  assign pins_s = pins_clean;
  // every pin, contactor feedback included, lags by the sync flops plus the filter

  rscs_sync #(
    .W(6),
    .DEB(DEBOUNCE_CYC)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .din_i(pins_raw),
    .dout_o(pins_clean)
  );

  // ****************************************
  // relay ladder state
  // ****************************************
  logic run_relay_ff;
  logic jog_relay_ff;
  logic aux_a_ff;
  logic aux_b_ff;
  logic pb_relay_ff;
  logic coil_ff;
  logic ref_on_ff;
  logic enable_ff;
  logic nxt_run_relay;
  logic nxt_jog_relay;
  logic start_run;
  logic start_jog;
  logic coast;

  assign coast = (stop_style_jumper_i == `RSCS_STOP_COAST);
  assign start_run = pins_s.run_pb && pins_s.interlock_ok && !pins_s.stop_pb;
  // jog is refused while run holds, so the two never fight over the coil
  assign start_jog = pins_s.jog_pb && pins_s.interlock_ok && !pins_s.stop_pb && !run_relay_ff;
  // the seal only holds while aux relay a confirms the contactor picked up
  logic seal_in;
  assign seal_in = run_relay_ff && aux_a_ff;

  // run and jog relays; three-wire seals in through run contact plus aux relay a
  always_comb begin
    nxt_run_relay = 1'b0;
    nxt_jog_relay = 1'b0;
    if (pins_s.interlock_ok && !pins_s.stop_pb) begin
      if (three_wire_i) begin
        nxt_run_relay = start_run || seal_in;
      end else begin
        nxt_run_relay = start_run;
      end
      // jog never seals; it drops as soon as its contact opens
      nxt_jog_relay = start_jog;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_relay_ff <= 1'b0;
      jog_relay_ff <= 1'b0;
    end else begin
      run_relay_ff <= nxt_run_relay;
      jog_relay_ff <= nxt_jog_relay;
    end
  end

  // contactor coil: driven by run/jog contact, or held by phaseback relay in series with aux b
  // aux b in series stops the phaseback relay sealing in before the contactor picks up
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      coil_ff <= 1'b0;
    end else begin
      coil_ff <= pins_s.interlock_ok &&
                 (run_relay_ff || jog_relay_ff || (pb_relay_ff && aux_b_ff));
    end
  end

  // aux relays follow the contactor's own aux contact; in three-wire, losing it locks out until a new run
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aux_a_ff <= 1'b0;
      aux_b_ff <= 1'b0;
    end else begin
      aux_a_ff <= pins_s.contactor_aux;
      aux_b_ff <= pins_s.contactor_aux;
    end
  end

  // ****************************************
  // control inputs to the firing logic
  // ****************************************
  logic cmd_active;
  // either relay counts as a live command for reference, enable and spare contact
  assign cmd_active = run_relay_ff || jog_relay_ff;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ref_on_ff <= 1'b0;
      enable_ff <= 1'b0;
    end else begin
      ref_on_ff <= aux_a_ff && cmd_active;
      // coast stop or loss of the contactor drops enable without waiting for zero speed
      if (aux_a_ff && cmd_active) begin
        enable_ff <= 1'b1;
      end else if (coast || !aux_a_ff) begin
        enable_ff <= 1'b0;
      end else if (at_zero_speed_i) begin
        // ramp stop keeps enable until the motor reaches zero speed
        enable_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // power stage disable delay
  // ****************************************
  logic stage_en_ff;
  logic [$clog2(DISABLE_DELAY_CYC+1)-1:0] off_cnt_ff;
  // a new enable restarts the count, so every release gets the full delay

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stage_en_ff <= 1'b0;
      off_cnt_ff <= '0;
    end else if (enable_ff) begin
      stage_en_ff <= 1'b1;
      off_cnt_ff <= '0;
    end else if (stage_en_ff) begin
      if (off_cnt_ff == ($clog2(DISABLE_DELAY_CYC+1))'(DISABLE_DELAY_CYC - 1)) begin
        stage_en_ff <= 1'b0;
        off_cnt_ff <= '0;
      end else begin
        off_cnt_ff <= off_cnt_ff + 1'b1;
      end
    end
  end

  // ****************************************
  // phaseback status and relay
  // ****************************************
  logic fwd_ff;
  // the relay trails the status by a cycle, as the status output drives its coil
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fwd_ff <= 1'b0;
      pb_relay_ff <= 1'b0;
    end else begin
      // phased forward only while firing with an unclamped reference or still decelerating
      fwd_ff <= stage_en_ff && enable_ff && (ref_on_ff || !at_zero_speed_i);
      pb_relay_ff <= fwd_ff;
    end
  end

  // ****************************************
  // reference selection
  // ****************************************
  logic signed [REF_W-1:0] nxt_ref;
  // a clamped reference is forced to zero, so a restart ramps up from rest
  logic jog_sel;
  assign jog_sel = jog_relay_ff && ref_on_ff;

  always_comb begin
    nxt_ref = '0;
    if (ref_on_ff) begin
      nxt_ref = jog_sel ? jog_ref_i : speed_ref_i;
      // reverse acts on whichever reference is active
      if (pins_s.reverse_sw) begin
        nxt_ref = -nxt_ref;
      end
    end
  end

  logic signed [REF_W-1:0] ref_ff;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ref_ff <= '0;
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  // ****************************************
  // fault and programmable relays
  // ****************************************
  logic no_fault_ff;
  logic trip_ff;
  logic relay_one_ff;
  logic relay_two_ff;
  // trip follows the filtered interlock, so it lasts only while the contact is open
  // an open interlock is a fault too, so it also drops the no-fault relay
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      no_fault_ff <= 1'b0;
      trip_ff <= 1'b0;
      relay_one_ff <= 1'b0;
      relay_two_ff <= 1'b0;
    end else begin
      no_fault_ff <= power_ok_i && !drive_fault_i && pins_s.interlock_ok;
      trip_ff <= !pins_s.interlock_ok;
      relay_one_ff <= pins_s.reverse_sw;
      relay_two_ff <= relay_two_cmd_i;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign ctrl_o.power_stage_en = stage_en_ff;
  assign ctrl_o.ref_unclamped = ref_on_ff;
  assign ctrl_o.jog_select = jog_sel;
  assign ctrl_o.reverse = relay_one_ff;
  assign ctrl_o.phaseback = fwd_ff;
  assign ref_o = ref_ff;
  assign contactor_coil_o = coil_ff;
  // the normally closed aux b contact opens on pick-up and cuts the coil to holding voltage
  assign coil_reduced_o = aux_b_ff;
  assign contactor_aux_relay_a_o = aux_a_ff;
  assign contactor_aux_relay_b_o = aux_b_ff;
  assign zero_speed_phaseback_relay_o = pb_relay_ff;
  assign phaseback_status_output_o = fwd_ff;
  assign spare_aux_contact_o = aux_b_ff && cmd_active;
  // jumper only flips contact sense, so the polarity xor is a pure contact model
  assign no_fault_relay_o = no_fault_ff ^ nofault_contact_polarity_jumper_i;
  assign trip_relay_o = !trip_ff;
  assign external_trip_o = trip_ff;
  assign programmable_relay_one_o = relay_one_ff;
  assign programmable_relay_two_o = relay_two_ff;
  // relay two drives reset by default; other jumper position routes it to the spare input
  assign drive_reset_o = relay_two_ff && !relay_two_function_jumper_i;
  assign relay_two_programmable_input_o = relay_two_ff && relay_two_function_jumper_i;
endmodule

// ===== tb/rscs_checker.sv
// port assertions for the run/stop contactor sequencer
`timescale 1ns/1ps
module rscs_checker
  import rscs_pkg::*;
#(
  parameter int DISABLE_DELAY_CYC = 20
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire rscs_pkg::rscs_pins_t pins_i,
  input wire logic stop_style_jumper_i,
  input wire logic relay_two_function_jumper_i,
  input wire logic nofault_contact_polarity_jumper_i,
  input wire logic power_ok_i,
  input wire logic drive_fault_i,
  input wire rscs_pkg::rscs_ctrl_t ctrl_o,
  input wire logic signed [15:0] ref_o,
  input wire logic contactor_coil_o,
  input wire logic coil_reduced_o,
  input wire logic contactor_aux_relay_b_o,
  input wire logic zero_speed_phaseback_relay_o,
  input wire logic phaseback_status_output_o,
  input wire logic spare_aux_contact_o,
  input wire logic no_fault_relay_o,
  input wire logic trip_relay_o,
  input wire logic external_trip_o,
  input wire logic programmable_relay_two_o,
  input wire logic drive_reset_o
);
  // ****************************************
  // rules on the outputs
  // ****************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  int on_cnt_ff;
  // counts how long the stage has been on, so a short enable still shows the full off delay
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !ctrl_o.power_stage_en) on_cnt_ff <= 0;
    else on_cnt_ff <= on_cnt_ff + 1;
  end
  a_stage_off_delay: assert property ($fell(ctrl_o.power_stage_en) && !$past(rst_i) && pins_i.interlock_ok
    |-> on_cnt_ff >= DISABLE_DELAY_CYC - 2) else $error("power stage dropped too early");
  a_status_needs_stage: assert property (phaseback_status_output_o |-> $past(ctrl_o.power_stage_en))
    else $error("phaseback status without power stage");
  a_pb_relay_gated: assert property ($rose(zero_speed_phaseback_relay_o) |-> $past(contactor_aux_relay_b_o))
    else $error("phaseback relay closed before aux relay b");
  a_coil_held_pb: assert property ($fell(contactor_coil_o) && !$past(rst_i) && pins_i.interlock_ok
    && !stop_style_jumper_i |-> !zero_speed_phaseback_relay_o) else $error("coil opened while phaseback relay held");
  a_reduced_after_pickup: assert property ($rose(coil_reduced_o) |-> $past(contactor_coil_o, 8))
    else $error("reduced coil before contactor pick-up");
  a_spare_follows_b: assert property (!contactor_aux_relay_b_o |-> !spare_aux_contact_o)
    else $error("spare contact closed without aux relay b");
  a_ref_clamped: assert property (!ctrl_o.ref_unclamped && !$past(ctrl_o.ref_unclamped) |-> ref_o == 16'sh0000)
    else $error("reference not zero while clamped");
  a_trip_open: assert property (external_trip_o |-> !trip_relay_o)
    else $error("external trip while trip relay held");
  a_nofault_good: assert property ((power_ok_i && !drive_fault_i && pins_i.interlock_ok
    && !nofault_contact_polarity_jumper_i)[*8] |-> no_fault_relay_o) else $error("no-fault relay off when healthy");
  a_nofault_nopower: assert property ((!power_ok_i)[*3] |-> no_fault_relay_o == nofault_contact_polarity_jumper_i)
    else $error("no-fault relay on without power");
  a_relay_two_reset: assert property ((!relay_two_function_jumper_i)[*3] |-> drive_reset_o == programmable_relay_two_o)
    else $error("relay two not driving reset");
  c_coil_drop: cover property ($fell(contactor_coil_o));
  c_pb_hold: cover property ($rose(zero_speed_phaseback_relay_o));
  c_trip: cover property ($rose(external_trip_o));
endmodule

// ===== tb/rscs_partner.sv
// operator station and motor contactor model
`timescale 1ns/1ps
module rscs_partner
  import rscs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic coil_i,
  input wire logic [4:0] btn_i,
  output rscs_pkg::rscs_pins_t pins_o
);
  // ****************************************
  // contactor armature
  // ****************************************
  logic [3:0] aux_ff = 4'h0;
  // armature lags the coil both ways, so aux never tracks the coil in the same cycle
  always_ff @(posedge clk_sys_i) begin
    aux_ff <= {aux_ff[2:0], coil_i};
  end
  // btn_i is run, jog, stop, interlock ok, reverse
  assign pins_o = {btn_i[4:1], aux_ff[3], btn_i[0]};
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the run/stop contactor sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %0h expected %0h", $time, a, b); end end
`define WT(c) for (int k = 0; k < 300 && !(c); k++) @(negedge clk_sys_i);
module tb_top;
  import rscs_pkg::*;
  localparam int DIS = 20;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] btn = 5'h02;
  logic stop_style_jumper_i = 1'b0, three_wire_i = 1'b1, relay_two_function_jumper_i = 1'b0;
  logic nofault_contact_polarity_jumper_i = 1'b0, power_ok_i = 1'b1, drive_fault_i = 1'b0;
  logic at_zero_speed_i = 1'b0, relay_two_cmd_i = 1'b0;
  logic signed [15:0] speed_ref_i = 16'sh0123, jog_ref_i = 16'sh0045, ref_o;
  rscs_pins_t pins_i;
  rscs_ctrl_t ctrl_o;
  logic contactor_coil_o, coil_reduced_o, contactor_aux_relay_a_o, contactor_aux_relay_b_o;
  logic zero_speed_phaseback_relay_o, phaseback_status_output_o, spare_aux_contact_o, no_fault_relay_o;
  logic trip_relay_o, external_trip_o, programmable_relay_one_o, programmable_relay_two_o;
  logic drive_reset_o, relay_two_programmable_input_o;
  int n_errors = 0;
  int checks_done = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  // short counts keep the run brief
  rscs_top #(.DISABLE_DELAY_CYC(DIS), .DEBOUNCE_CYC(2)) rscs_top_inst (.clk_sys_i, .rst_i, .pins_i,
    .stop_style_jumper_i, .three_wire_i, .relay_two_function_jumper_i, .nofault_contact_polarity_jumper_i,
    .power_ok_i, .drive_fault_i, .at_zero_speed_i, .relay_two_cmd_i, .speed_ref_i, .jog_ref_i, .ctrl_o,
    .ref_o, .contactor_coil_o, .coil_reduced_o, .contactor_aux_relay_a_o, .contactor_aux_relay_b_o,
    .zero_speed_phaseback_relay_o, .phaseback_status_output_o, .spare_aux_contact_o, .no_fault_relay_o,
    .trip_relay_o, .external_trip_o, .programmable_relay_one_o, .programmable_relay_two_o, .drive_reset_o,
    .relay_two_programmable_input_o);
  rscs_partner rscs_partner_inst (.clk_sys_i, .coil_i(contactor_coil_o), .btn_i(btn), .pins_o(pins_i));
  // ****************************************
  // tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // hold a button until the contactor aux is back and the run circuit has sealed in
  task automatic press(input int idx);
    btn[idx] = 1'b1;
    step(16);
    btn[idx] = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    step(10);
    rst_i = 1'b0;
    step(2);
    `CHK(ctrl_o.power_stage_en, 1'b0)
    btn[2] = 1'b1;
    press(4);
    step(6);
    `CHK(contactor_coil_o, 1'b0)
    btn[2] = 1'b0;
    press(4);
    `WT(zero_speed_phaseback_relay_o)
    `CHK(contactor_coil_o, 1'b1)
    `CHK(ref_o, speed_ref_i)
    `CHK(coil_reduced_o, 1'b1)
    `CHK(spare_aux_contact_o, 1'b1)
    `CHK(phaseback_status_output_o, 1'b1)
    btn[0] = 1'b1;
    step(12);
    `CHK(ref_o, -speed_ref_i)
    `CHK(programmable_relay_one_o, 1'b1)
    `CHK(ctrl_o.reverse, 1'b1)
    btn[0] = 1'b0;
    press(2);
    step(8);
    `CHK(ref_o, 16'sh0000)
    `CHK(ctrl_o.power_stage_en, 1'b1)
    `CHK(contactor_coil_o, 1'b1)
    at_zero_speed_i = 1'b1;
    `WT(!contactor_coil_o)
    step(20);
    `CHK(contactor_coil_o, 1'b0)
    `CHK(contactor_aux_relay_a_o, 1'b0)
    $display("test ramp stop done");
    three_wire_i = 1'b0;
    stop_style_jumper_i = 1'b1;
    at_zero_speed_i = 1'b0;
    btn[3] = 1'b1;
    `WT(ctrl_o.power_stage_en)
    step(4);
    `CHK(ctrl_o.jog_select, 1'b1)
    `CHK(ref_o, jog_ref_i)
    btn[3] = 1'b0;
    step(16);
    `CHK(contactor_coil_o, 1'b0)
    `CHK(ctrl_o.phaseback, 1'b0)
    `CHK(ctrl_o.power_stage_en, 1'b1)
    step(DIS);
    `CHK(ctrl_o.power_stage_en, 1'b0)
    btn[4] = 1'b1;
    `WT(contactor_coil_o)
    btn[4] = 1'b0;
    step(16);
    `CHK(contactor_coil_o, 1'b0)
    $display("test two-wire coast done");
    three_wire_i = 1'b1;
    stop_style_jumper_i = 1'b0;
    step(DIS);
    press(4);
    `WT(zero_speed_phaseback_relay_o)
    btn[1] = 1'b0;
    step(12);
    `CHK(external_trip_o, 1'b1)
    `CHK(trip_relay_o, 1'b0)
    `CHK(contactor_coil_o, 1'b0)
    btn[1] = 1'b1;
    step(12);
    `CHK(external_trip_o, 1'b0)
    `CHK(contactor_coil_o, 1'b0)
    $display("test interlock done");
    power_ok_i = 1'b0;
    step(4);
    `CHK(no_fault_relay_o, 1'b0)
    nofault_contact_polarity_jumper_i = 1'b1;
    step(4);
    `CHK(no_fault_relay_o, 1'b1)
    power_ok_i = 1'b1;
    nofault_contact_polarity_jumper_i = 1'b0;
    relay_two_cmd_i = 1'b1;
    step(10);
    `CHK(no_fault_relay_o, 1'b1)
    `CHK(drive_reset_o, 1'b1)
    `CHK(programmable_relay_two_o, 1'b1)
    `CHK(relay_two_programmable_input_o, 1'b0)
    relay_two_function_jumper_i = 1'b1;
    step(4);
    `CHK(relay_two_programmable_input_o, 1'b1)
    `CHK(drive_reset_o, 1'b0)
    $display("test relays done");
    complete_run();
  end
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
endmodule
bind rscs_top rscs_checker #(.DISABLE_DELAY_CYC(DISABLE_DELAY_CYC)) rscs_checker_inst (.clk_sys_i, .rst_i,
  .pins_i, .stop_style_jumper_i, .relay_two_function_jumper_i, .nofault_contact_polarity_jumper_i, .power_ok_i,
  .drive_fault_i, .ctrl_o, .ref_o, .contactor_coil_o, .coil_reduced_o, .contactor_aux_relay_b_o,
  .zero_speed_phaseback_relay_o, .phaseback_status_output_o, .spare_aux_contact_o, .no_fault_relay_o,
  .trip_relay_o, .external_trip_o, .programmable_relay_two_o, .drive_reset_o);
